// File: design/wdt_pkg.sv
// constants shared by the watchdog design
package wdt_pkg;

  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam int             ADDR_W    = 8;
  localparam logic [7:0]     MODE_OFS  = 8'h00;
  localparam logic [7:0]     CODE_OFS  = 8'h04;
  localparam logic [7:0]     STAT_OFS  = 8'h08;
  localparam logic [7:0]     MASK_OFS  = 8'h0C;
  localparam logic [7:0]     STATE_OFS = 8'h10;
  localparam logic [7:0]     COUNT_OFS = 8'h14;

  // ****************************************************************
  // mode register fields and reset values
  // ****************************************************************
  localparam int             ENABLE_POS  = 7;
  localparam int             PERIOD_LSB  = 4;
  localparam int             IDLE_POS    = 2;
  localparam int             OUTCOME_POS = 1;
  localparam logic           ENABLE_RST  = 1'h1;
  localparam logic [2:0]     PERIOD_RST  = 3'h0;
  localparam logic           IDLE_RST    = 1'h0;
  localparam logic           OUTCOME_RST = 1'h1;

  // ****************************************************************
  // codes, periods, timing
  // ****************************************************************
  localparam logic [7:0]     CODE_DISABLE    = 8'hB1;
  localparam logic [7:0]     CODE_CLEAR      = 8'h4E;
  localparam int             PERIOD_BASE_EXP = 15;
  localparam int             PERIOD_STEP_EXP = 2;
  localparam logic [2:0]     PERIOD_MAX_CODE = 3'h5;
  localparam int             RESET_HOLD_CYC  = 32;

  // ****************************************************************
  // event status bits
  // ****************************************************************
  localparam int             EVT_OVERFLOW = 0;
  localparam int             EVT_CLEAR    = 1;
  localparam int             EVT_BADCODE  = 2;
  localparam int             EVT_N        = 3;

endpackage

// File: design/wdt_sticky_flag.sv
// sticky event flag, set wins over clear
`timescale 1ns/1ns
`default_nettype none
module wdt_sticky_flag (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output var  logic flag_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_o <= 1'h0;
    end else begin
      flag_o <= set_i | (flag_o & ~clr_i);
    end
  end
endmodule
`default_nettype wire

// File: design/wdt_reset_stretch.sv
// stretches a start pulse into a fixed-length reset level
`timescale 1ns/1ns
`default_nettype none
module wdt_reset_stretch #(
  parameter int HOLD = wdt_pkg::RESET_HOLD_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  output var  logic hold_o
);
  localparam int CW = $clog2(HOLD + 1);
  localparam logic [CW-1:0] LAST = CW'(HOLD - 1);
  logic [CW-1:0] left;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_o <= 1'h0;
      left   <= '0;
    end else if (start_i && !hold_o) begin
      hold_o <= 1'h1;
      left   <= LAST;
    end else if (hold_o) begin
      hold_o <= (left != '0);
      left   <= left - CW'(1);
    end
  end
endmodule
`default_nettype wire

// File: design/runaway_watchdog_timer.sv
// runaway watchdog timer with a classic wishbone register slave
//
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module runaway_watchdog_timer #(
  parameter int PERIOD_BASE_EXP = wdt_pkg::PERIOD_BASE_EXP
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [wdt_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output var  logic [31:0]               wb_dat_o,
  output var  logic                      wb_ack_o,
  input  wire logic                      idle_i,
  input  wire logic                      debug_i,
  output var  logic                      watchdog_nmi_request_o,
  output var  logic                      nmi_source_flag0_set_o,
  output var  logic                      watchdog_out_n_o,
  output var  logic                      chip_reset_o,
  output var  logic                      clock_select_restore_o,
  output var  logic                      irq_o
);
  localparam int CNT_W = PERIOD_BASE_EXP
                         + wdt_pkg::PERIOD_STEP_EXP * int'(wdt_pkg::PERIOD_MAX_CODE);

  // ****************************************************************
  // state
  // ****************************************************************
  logic                      enable_bit;
  logic [2:0]                period_select;
  logic                      idle_run_select;
  logic                      outcome_select;
  logic                      running;
  logic [CNT_W-1:0]          count;
  logic [wdt_pkg::EVT_N-1:0] status;
  logic [wdt_pkg::EVT_N-1:0] mask;
  logic                      stretch_hold;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire bus_req  = wb_cyc_i & wb_stb_i;
  wire wr_fire  = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
  wire hit_mode = (wb_adr_i == wdt_pkg::MODE_OFS);
  wire hit_code = (wb_adr_i == wdt_pkg::CODE_OFS);
  wire hit_stat = (wb_adr_i == wdt_pkg::STAT_OFS);
  wire hit_mask = (wb_adr_i == wdt_pkg::MASK_OFS);
  wire hit_st   = (wb_adr_i == wdt_pkg::STATE_OFS);
  wire hit_cnt  = (wb_adr_i == wdt_pkg::COUNT_OFS);

  wire       mode_wr    = wr_fire & hit_mode;
  wire       code_wr    = wr_fire & hit_code;
  wire [7:0] code_byte  = wb_dat_i[7:0];
  wire       is_clear   = (code_byte == wdt_pkg::CODE_CLEAR);
  wire       is_disable = (code_byte == wdt_pkg::CODE_DISABLE);
  wire clear_fire   = code_wr & is_clear;
  wire disable_fire = code_wr & is_disable & ~enable_bit;
  wire bad_code     = code_wr & ~is_clear & ~is_disable;

  // ****************************************************************
  // counting and overflow
  // ****************************************************************
  wire [2:0] eff_code  = (period_select > wdt_pkg::PERIOD_MAX_CODE)
                         ? wdt_pkg::PERIOD_MAX_CODE : period_select;
  wire [5:0] shift_amt = 6'(wdt_pkg::PERIOD_STEP_EXP
                            * int'(wdt_pkg::PERIOD_MAX_CODE - eff_code));
  wire [CNT_W-1:0] terminal = {CNT_W{1'h1}} >> shift_amt;
  wire count_adv = running & ~debug_i & ~(idle_i & ~idle_run_select);
  wire overflow  = count_adv & (count == terminal);
  wire nmi_event = overflow & ~outcome_select;
  wire rst_event = overflow & outcome_select;

  // ****************************************************************
  // read data
  // ****************************************************************
  wire [31:0] mode_rd = {24'h000000, enable_bit, period_select, 1'h0,
                         idle_run_select, outcome_select, 1'h0};
  wire [31:0] stat_rd = {{(32 - wdt_pkg::EVT_N){1'b0}}, status};
  wire [31:0] mask_rd = {{(32 - wdt_pkg::EVT_N){1'b0}}, mask};
  wire [31:0] st_rd   = {29'h00000000, ~watchdog_out_n_o, enable_bit, running};
  wire [31:0] cnt_rd  = 32'(count);
  wire [31:0] next_dat = hit_mode ? mode_rd :
                         hit_stat ? stat_rd :
                         hit_mask ? mask_rd :
                         hit_st   ? st_rd   :
                         hit_cnt  ? cnt_rd  : 32'h00000000;

  // ****************************************************************
  // bus slave
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'h0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      wb_dat_o <= (bus_req & ~wb_ack_o & ~wb_we_i) ? next_dat : 32'h00000000;
    end
  end

  // ****************************************************************
  // mode and mask registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_bit      <= wdt_pkg::ENABLE_RST;
      period_select   <= wdt_pkg::PERIOD_RST;
      idle_run_select <= wdt_pkg::IDLE_RST;
      outcome_select  <= wdt_pkg::OUTCOME_RST;
      mask            <= '0;
    end else begin
      if (mode_wr) begin
        enable_bit      <= wb_dat_i[wdt_pkg::ENABLE_POS];
        period_select   <= wb_dat_i[wdt_pkg::PERIOD_LSB +: 3];
        idle_run_select <= wb_dat_i[wdt_pkg::IDLE_POS];
        outcome_select  <= wb_dat_i[wdt_pkg::OUTCOME_POS];
      end
      if (wr_fire && hit_mask) begin
        mask <= wb_dat_i[wdt_pkg::EVT_N-1:0];
      end
    end
  end

  // ****************************************************************
  // run state and counter
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      running <= 1'h1;
    end else if (mode_wr && wb_dat_i[wdt_pkg::ENABLE_POS]) begin
      running <= 1'h1;
    end else if (disable_fire) begin
      running <= 1'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
    end else if (clear_fire || disable_fire) begin
      count <= '0;
    end else if (overflow) begin
      count <= '0;
    end else if (count_adv) begin
      count <= count + CNT_W'(1);
    end
  end

  // ****************************************************************
  // malfunction outputs
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      watchdog_nmi_request_o <= 1'h0;
      nmi_source_flag0_set_o <= 1'h0;
      watchdog_out_n_o       <= 1'h1;
      chip_reset_o           <= 1'h0;
      clock_select_restore_o <= 1'h0;
      irq_o                  <= 1'h0;
    end else begin
      watchdog_nmi_request_o <= nmi_event;
      nmi_source_flag0_set_o <= nmi_event;
      if (overflow) begin
        watchdog_out_n_o <= 1'h0;
      end else if (clear_fire) begin
        watchdog_out_n_o <= 1'h1;
      end
      chip_reset_o           <= stretch_hold;
      clock_select_restore_o <= stretch_hold;
      irq_o                  <= |(status & mask);
    end
  end

  wdt_reset_stretch #(
    .HOLD (wdt_pkg::RESET_HOLD_CYC)
  ) u_stretch (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (rst_event),
    .hold_o  (stretch_hold)
  );

  // ****************************************************************
  // interrupt status flags
  // ****************************************************************
  wire [wdt_pkg::EVT_N-1:0] evt_set = {bad_code, clear_fire, overflow};
  wire [wdt_pkg::EVT_N-1:0] evt_clr =
    (wr_fire && hit_stat) ? wb_dat_i[wdt_pkg::EVT_N-1:0] : '0;

  for (genvar i = 0; i < wdt_pkg::EVT_N; i++) begin : g_evt
    wdt_sticky_flag u_flag (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .set_i  (evt_set[i]),
      .clr_i  (evt_clr[i]),
      .flag_o (status[i])
    );
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [7:0] hold_len;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_len <= 8'h00;
    end else begin
      hold_len <= chip_reset_o ? hold_len + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_RESET_ENABLE: assert property (
    $fell(rst_i) |-> enable_bit && running && outcome_select)
    else $error("watchdog not enabled after reset");
  AST_RESET_PERIOD: assert property (
    $fell(rst_i) |-> period_select == 3'h0)
    else $error("period not shortest after reset");
  AST_COUNT_START: assert property (
    ($fell(rst_i) && !debug_i && !idle_i) |=> count == CNT_W'(1))
    else $error("counter did not start at reset release");
  AST_OVERFLOW_NMI: assert property (
    (count_adv && count == terminal && !outcome_select)
      |=> watchdog_nmi_request_o && nmi_source_flag0_set_o && !watchdog_out_n_o)
    else $error("overflow did not raise the nmi request");
  AST_NMI_FLAG: assert property (
    watchdog_nmi_request_o |-> nmi_source_flag0_set_o)
    else $error("nmi raised without source flag");
  AST_RESET_LEN: assert property (
    $fell(chip_reset_o) |-> hold_len == 8'h20)
    else $error("overflow reset not held 32 cycles");
  AST_RESET_CLK: assert property (
    chip_reset_o |-> clock_select_restore_o)
    else $error("clock selection not restored during reset");
  AST_CLEAR: assert property (
    clear_fire |=> count == '0 ##1 count == CNT_W'($past(count_adv)))
    else $error("clear code did not zero the counter");
  AST_IDLE_FREEZE: assert property (
    (idle_i && !idle_run_select && !clear_fire && !disable_fire) |=> $stable(count))
    else $error("counter moved in idle with idle run off");
  AST_DEBUG_HALT: assert property (
    (debug_i && !clear_fire && !disable_fire) |=> $stable(count))
    else $error("counter moved in debug mode");
  AST_OUT_HIGH: assert property (
    (clear_fire && !overflow) |=> watchdog_out_n_o)
    else $error("out did not return high on clear");
  AST_DISABLE_GUARD: assert property (
    (code_wr && is_disable && enable_bit) |=> running)
    else $error("disable code stopped an enabled watchdog");
  AST_CODE_READ: assert property (
    (wb_ack_o && !wb_we_i && hit_code) |-> wb_dat_o == 32'h00000000)
    else $error("code register read nonzero");

  AST_PERIOD_LEN: assert property (
    overflow |-> (32'(count) + 32'h00000001) == (32'h00000001 << (PERIOD_BASE_EXP
      + wdt_pkg::PERIOD_STEP_EXP * int'((period_select > wdt_pkg::PERIOD_MAX_CODE)
      ? wdt_pkg::PERIOD_MAX_CODE : period_select))))
    else $error("overflow not at the selected period");

  AST_OUTCOME_RESET: assert property (
    (overflow && outcome_select && !stretch_hold)
      |=> stretch_hold && !watchdog_nmi_request_o)
    else $error("reset outcome did not start the reset hold");

  AST_OUT_LOW: assert property (
    overflow |=> !watchdog_out_n_o)
    else $error("out not low after overflow");

  AST_DISABLE_STOP: assert property (
    disable_fire |=> !running && count == '0)
    else $error("disable sequence did not stop the counter");

  AST_ENABLE_RUN: assert property (
    (mode_wr && wb_dat_i[wdt_pkg::ENABLE_POS]) |=> running && enable_bit)
    else $error("enable write did not restart the watchdog");

  AST_RESERVED_CODE: assert property (
    (bad_code && count_adv && !overflow) |=> count == $past(count) + CNT_W'(1))
    else $error("reserved code disturbed the counter");

endmodule
`default_nettype wire

// File: verification/core_partner.sv
// behavioural model of the core's nmi and reset receiving logic
`timescale 1ns/1ns
`default_nettype none
module core_partner (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic nmi_i,
  input  wire logic flag0_i,
  input  wire logic reset_i,
  input  wire logic restore_i,
  output var  int   nmi_count_o,
  output var  int   reset_len_o,
  output var  int   pair_bad_o
);
  // ****************************************************************
  // nmi counting, reset length, paired outputs
  // ****************************************************************
  int run;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_count_o <= 0;
      reset_len_o <= 0;
      pair_bad_o  <= 0;
      run         <= 0;
    end else begin
      if (nmi_i === 1'b1) nmi_count_o <= nmi_count_o + 1;
      if (flag0_i !== nmi_i) pair_bad_o <= pair_bad_o + 1;
      if (restore_i !== reset_i) pair_bad_o <= pair_bad_o + 1;
      run <= (reset_i === 1'b1) ? run + 1 : 0;
      if (reset_i !== 1'b1 && run != 0) reset_len_o <= run;
    end
  end
endmodule
`default_nettype wire

// File: verification/runaway_watchdog_timer_test.sv
// self-checking testbench of the runaway watchdog timer
`timescale 1ns/1ns
`default_nettype none
module runaway_watchdog_timer_test;
  // ****************************************************************
  // signals, design and core model
  // ****************************************************************
  logic        clk_i, rst_i, cyc, stb, we, idle, dbg;
  logic [7:0]  adr;
  logic [31:0] dat, rdat, rd_bus;
  logic [3:0]  sel;
  logic        ack, nmi, flag0, out_n, chip_rst, restore, irq;
  int          bad_count, n_checks, nmi_cnt, rst_len, pair_bad, n, base;
  runaway_watchdog_timer #(.PERIOD_BASE_EXP(3)) i_runaway_watchdog_timer (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd_bus), .wb_ack_o(ack),
    .idle_i(idle), .debug_i(dbg), .watchdog_nmi_request_o(nmi),
    .nmi_source_flag0_set_o(flag0), .watchdog_out_n_o(out_n), .chip_reset_o(chip_rst),
    .clock_select_restore_o(restore), .irq_o(irq));
  core_partner i_core_partner (
    .clk_i(clk_i), .rst_i(rst_i), .nmi_i(nmi), .flag0_i(flag0), .reset_i(chip_rst),
    .restore_i(restore), .nmi_count_o(nmi_cnt), .reset_len_o(rst_len),
    .pair_bad_o(pair_bad));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 50);
    rdat = rd_bus;
    chk("wb ack", 1, k < 50);
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
  endtask
  function automatic logic [31:0] mv(logic en, logic [2:0] p, logic idl, logic oc);
    mv = 32'h0;
    mv[wdt_pkg::ENABLE_POS] = en;
    mv[wdt_pkg::PERIOD_LSB +: 3] = p;
    mv[wdt_pkg::IDLE_POS] = idl;
    mv[wdt_pkg::OUTCOME_POS] = oc;
  endfunction
  task automatic wait_nmi(input int lim, output int k);
    k = 0;
    do begin @(posedge clk_i); k++; end while (nmi !== 1'b1 && k < lim);
    chk("nmi seen", 1, nmi === 1'b1);
  endtask
  task automatic quiet(input string nm);
    base = nmi_cnt;
    repeat (30) @(posedge clk_i);
    chk(nm, base, nmi_cnt);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    sel <= 4'h0;
    wb(1, wdt_pkg::MODE_OFS, 32'h0);
    sel <= 4'hF;
    wb(0, wdt_pkg::MODE_OFS, 0); chk("mode reset", 32'h0000_0082, rdat);
    wb(0, wdt_pkg::CODE_OFS, 0); chk("code read", 32'h0, rdat);
    wb(0, 8'h40, 0); chk("unmapped", 32'h0, rdat);
    n = 0;
    while (chip_rst !== 1'b1 && n < 30) begin @(posedge clk_i); n++; end
    chk("reset start", 1, chip_rst === 1'b1);
    repeat (40) @(posedge clk_i);
    chk("reset length", 32, rst_len);
  endtask
  task automatic t_nmi;
    wb(1, wdt_pkg::MODE_OFS, mv(1, 0, 0, 0));
    repeat (40) @(posedge clk_i);
    wb(1, wdt_pkg::CODE_OFS, 32'h4E);
    wb(1, wdt_pkg::MASK_OFS, 32'h1);
    wait_nmi(40, n);
    chk("flag0", 1, flag0);
    chk("out low", 0, out_n);
    chk("no reset", 0, chip_rst);
    @(posedge clk_i);
    chk("irq up", 1, irq);
    wb(1, wdt_pkg::CODE_OFS, 32'h4E);
    chk("out high", 1, out_n);
    wb(1, wdt_pkg::MASK_OFS, 32'h0);
    @(posedge clk_i);
    chk("irq masked", 0, irq);
  endtask
  task automatic t_periods;
    for (int p = 0; p < 7; p++) begin
      wb(1, wdt_pkg::MODE_OFS, mv(1, p[2:0], 0, 0));
      wb(1, wdt_pkg::CODE_OFS, 32'h4E);
      wait_nmi(20000, n);
      wait_nmi(20000, n);
      chk("period", 1 << (3 + 2 * ((p > 5) ? 5 : p)), n);
    end
    wb(1, wdt_pkg::MODE_OFS, mv(1, 0, 0, 0));
    wb(1, wdt_pkg::CODE_OFS, 32'h4E);
    base = nmi_cnt;
    repeat (6) wb(1, wdt_pkg::CODE_OFS, 32'h4E);
    chk("clear holds off", base, nmi_cnt);
  endtask
  task automatic t_idle_debug;
    idle <= 1'b1;
    wb(1, wdt_pkg::CODE_OFS, 32'h4E);
    quiet("idle frozen");
    wb(1, wdt_pkg::MODE_OFS, mv(1, 0, 1, 0));
    wait_nmi(20, n);
    idle <= 1'b0;
    dbg <= 1'b1;
    wb(1, wdt_pkg::CODE_OFS, 32'h4E);
    quiet("debug frozen");
    dbg <= 1'b0;
    wait_nmi(20, n);
  endtask
  task automatic t_disable;
    wb(1, wdt_pkg::CODE_OFS, 32'hB1);
    wait_nmi(20, n);
    wb(1, wdt_pkg::CODE_OFS, 32'h55);
    wb(0, wdt_pkg::STAT_OFS, 0); chk("reserved flag", 1, rdat[2]);
    wb(1, wdt_pkg::MODE_OFS, mv(0, 0, 0, 0));
    wb(1, wdt_pkg::CODE_OFS, 32'hB1);
    quiet("disabled");
    wb(0, wdt_pkg::STATE_OFS, 0); chk("stopped", 0, rdat[0]);
    wb(1, wdt_pkg::MASK_OFS, 32'h7);
    @(posedge clk_i);
    chk("irq on", 1, irq);
    wb(1, wdt_pkg::STAT_OFS, 32'h7);
    wb(0, wdt_pkg::STAT_OFS, 0); chk("status clear", 0, rdat);
    chk("irq off", 0, irq);
    wb(1, wdt_pkg::MODE_OFS, mv(1, 0, 0, 0));
    wait_nmi(20, n);
    chk("pairing", 0, pair_bad);
  endtask
  // ****************************************************************
  // clock, reset, sequence, watchdog
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat = 32'h0;
    idle = 1'b0; dbg = 1'b0; bad_count = 0; n_checks = 0;
    sel = 4'hF;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_nmi();
    t_periods();
    t_idle_debug();
    t_disable();
    close_out();
  end
  initial begin
    #900000;
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
